// ### logic/tmccp_pkg.sv
// Package of register map, field layout and reset values for the timer channel
package tmccp_pkg;

  // Register byte offsets (one 32-bit word each)
  localparam logic [7:0] ADDR_RUN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_UP_COUNTER = 8'h0c;
  localparam logic [7:0] ADDR_COMPARE_0 = 8'h10;
  localparam logic [7:0] ADDR_COMPARE_1 = 8'h14;
  localparam logic [7:0] ADDR_CAPTURE_0 = 8'h18;
  localparam logic [7:0] ADDR_CAPTURE_1 = 8'h1c;

  // Bus, counter, prescaler and status widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  localparam int PRESCALE_W = 4;
  localparam int STATUS_W = 3;

  // Run control fields
  localparam int RUN_BIT = 0;
  localparam int SRC_LSB = 2;
  localparam int SRC_MSB = 3;

  // Status and mask fields
  localparam int ST_MATCH0 = 0;
  localparam int ST_MATCH1 = 1;
  localparam int ST_OVERFLOW = 2;

  // Reset values
  localparam logic [COUNT_W-1:0] COMPARE_RST = 16'h0000;
  localparam logic [STATUS_W-1:0] MASK_RST = 3'h0;
  localparam logic [1:0] SRC_RST = 2'h0;

  // Counter source: which prescaler output advances the up-counter
  typedef enum logic [1:0]
  {
    TMCCP_SRC_T1 = 2'b00,
    TMCCP_SRC_T4 = 2'b01,
    TMCCP_SRC_T16 = 2'b10,
    TMCCP_SRC_RSVD = 2'b11
  } tmccp_src_t;

  // Clock gear codes from the clock generator
  localparam logic [2:0] GEAR_DIV1 = 3'h0;
  localparam logic [2:0] GEAR_DIV2 = 3'h4;
  localparam logic [2:0] GEAR_DIV4 = 3'h5;
  localparam logic [2:0] GEAR_DIV8 = 3'h6;

  // Largest prescaler input select code (fperiph/32)
  localparam logic [2:0] PRCK_MAX = 3'h5;

endpackage : tmccp_pkg

// ### logic/tmccp_prescaler.sv
// Clock-gear, peripheral-clock and 4-bit prescaler enable generator
`timescale 1ns/1ps
module tmccp_prescaler
  import tmccp_pkg::*;
(
  input wire logic clk_sys_i,          // System clock, the undivided source clock
  input wire logic rst_i,              // Asynchronous reset, active high
  input wire logic periph_sel_i,       // 1: undivided source clock, 0: geared clock
  input wire logic [2:0] gear_sel_i,   // Clock gear code
  input wire logic [2:0] prck_sel_i,   // Prescaler input divider select
  input wire logic run_i,              // Prescaler run
  output logic tick_t1_o,              // Prescaler output pulse, input/2
  output logic tick_t4_o,              // Prescaler output pulse, input/8
  output logic tick_t16_o              // Prescaler output pulse, input/16
);

  logic [2:0] gear_cnt;
  logic [4:0] periph_cnt;
  logic [PRESCALE_W-1:0] prescaler;
  logic gear_en;
  logic periph_en;
  logic input_en;

  // Low-bits-all-ones test of a free counter gives a 2^n enable
  function automatic logic pow2_hit(input logic [4:0] cnt, input logic [2:0] n);
    logic [4:0] m;
    m = 5'h1f >> (3'h5 - n);
    pow2_hit = ((cnt & m) == m);
  endfunction : pow2_hit

  function automatic logic [2:0] gear_shift(input logic [2:0] code);
    case (code)
      GEAR_DIV2: gear_shift = 3'h1;
      GEAR_DIV4: gear_shift = 3'h2;
      GEAR_DIV8: gear_shift = 3'h3;
      default: gear_shift = 3'h0;
    endcase
  endfunction : gear_shift

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      gear_cnt <= 3'h0;
    else
      gear_cnt <= gear_cnt + 3'h1;
  end

  assign gear_en = pow2_hit({2'h0, gear_cnt}, gear_shift(gear_sel_i));
  assign periph_en = periph_sel_i ? 1'b1 : gear_en;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      periph_cnt <= 5'h00;
    else if (periph_en)
      periph_cnt <= periph_cnt + 5'h01;
  end

  // fperiph divided by 1..32; codes above the largest clamp to /32
  assign input_en = periph_en &&
    pow2_hit(periph_cnt, (prck_sel_i > PRCK_MAX) ? PRCK_MAX : prck_sel_i);

  // Run clears and stops the prescaler, or lets it count input ticks
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      prescaler <= '0;
    else if (!run_i)
      prescaler <= '0;
    else if (input_en)
      prescaler <= prescaler + 4'h1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_t1_o <= 1'b0;
      tick_t4_o <= 1'b0;
      tick_t16_o <= 1'b0;
    end
    else
    begin
      tick_t1_o <= run_i && input_en && (prescaler[0] == 1'b1);
      tick_t4_o <= run_i && input_en && (prescaler[2:0] == 3'h7);
      tick_t16_o <= run_i && input_en && (prescaler == 4'hf);
    end
  end

endmodule : tmccp_prescaler

// ### logic/tmccp_capture.sv
// Capture pin synchroniser with rising-edge latch of the up-counter
`timescale 1ns/1ps
module tmccp_capture
  import tmccp_pkg::*;
(
  input wire logic clk_sys_i,                 // System clock
  input wire logic rst_i,                     // Asynchronous reset, active high
  input wire logic pin_i,                     // Asynchronous capture pin
  input wire logic [COUNT_W-1:0] count_i,     // Current up-counter value
  output logic [COUNT_W-1:0] captured_o       // Latched counter value
);

  logic sync_ff1;
  logic sync_ff2;
  logic sync_prev;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
      sync_prev <= 1'b0;
    end
    else
    begin
      sync_ff1 <= pin_i;
      sync_ff2 <= sync_ff1;
      sync_prev <= sync_ff2;
    end
  end

  // Contents are undefined until the first capture, so no reset here
  always_ff @(posedge clk_sys_i)
  begin
    if (sync_ff2 && !sync_prev)
      captured_o <= count_i;
  end

endmodule : tmccp_capture

// ### logic/tmccp_timer.sv
// Timer channel: prescaler, 16-bit up-counter, two compares, two captures
// Function
// - Two read/write 16-bit compare registers, upper sixteen bits read zero.
// - Two read-only 16-bit capture registers latch the counter; undefined after reset.
// - A 4-bit prescaler produces the ticks that advance the up-counter.
// - Prescaler input is the peripheral clock divided by 1, 2, 4, 8, 16 or 32.
// - Peripheral clock is either the geared clock or the undivided source clock.
// - Run bit one starts the prescaler; zero clears and stops it.
// - All channels identical except the compare 0 reset value; one parameterised block per channel.
// - Counter equal to a compare value sets its match flag, even when masked.
`timescale 1ns/1ps
module tmccp_timer
  import tmccp_pkg::*;
#(
  parameter logic [COUNT_W-1:0] COMPARE0_RST = COMPARE_RST // Per-channel compare 0 reset value
)
(
  input wire logic clk_sys_i,                // System clock, 200 MHz
  input wire logic rst_i,                    // Asynchronous reset, active high
  input wire logic [ADDR_W-1:0] addr_i,      // Register byte address
  input wire logic [DATA_W-1:0] wdata_i,     // Write data
  input wire logic wr_i,                     // Write strobe
  input wire logic rd_i,                     // Read strobe
  output logic [DATA_W-1:0] rdata_o,         // Read data, cycle after strobe
  input wire logic periph_sel_i,             // Clock generator peripheral clock select
  input wire logic [2:0] gear_sel_i,         // Clock generator gear code
  input wire logic [2:0] prck_sel_i,         // Clock generator prescaler input select
  input wire logic capture0_pin_i,           // Capture 0 trigger pin
  input wire logic capture1_pin_i,           // Capture 1 trigger pin
  output logic irq_o,                        // Interrupt, high while unmasked flag set
  output logic prescaler_run_o               // Prescaler running state
);

  // Each channel is one instance of this module

  logic prescaler_run;
  tmccp_src_t count_src;
  logic [STATUS_W-1:0] status;
  logic [STATUS_W-1:0] mask;
  logic [COUNT_W-1:0] up_counter;
  logic [COUNT_W-1:0] compare_value_0;
  logic [COUNT_W-1:0] compare_value_1;
  logic [COUNT_W-1:0] captured_value_0;
  logic [COUNT_W-1:0] captured_value_1;
  logic tick_t1;
  logic tick_t4;
  logic tick_t16;
  logic count_tick;
  logic [COUNT_W-1:0] next_up_counter;
  logic [STATUS_W-1:0] event_set;
  logic [STATUS_W-1:0] w1c;
  logic [DATA_W-1:0] next_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  tmccp_prescaler u_prescaler
  (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .periph_sel_i (periph_sel_i),
    .gear_sel_i (gear_sel_i),
    .prck_sel_i (prck_sel_i),
    .run_i (prescaler_run),
    .tick_t1_o (tick_t1),
    .tick_t4_o (tick_t4),
    .tick_t16_o (tick_t16)
  );

  tmccp_capture u_capture0
  (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .pin_i (capture0_pin_i),
    .count_i (up_counter),
    .captured_o (captured_value_0)
  );

  tmccp_capture u_capture1
  (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .pin_i (capture1_pin_i),
    .count_i (up_counter),
    .captured_o (captured_value_1)
  );

  // Run control register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prescaler_run <= 1'b0;
      count_src <= tmccp_src_t'(SRC_RST);
    end
    else if (wr_i && hit(addr_i, ADDR_RUN_CONTROL))
    begin
      prescaler_run <= wdata_i[RUN_BIT];
      count_src <= tmccp_src_t'(wdata_i[SRC_MSB:SRC_LSB]);
    end
  end

  // Compare registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      compare_value_0 <= COMPARE0_RST;
      compare_value_1 <= COMPARE_RST;
    end
    else if (wr_i)
    begin
      if (hit(addr_i, ADDR_COMPARE_0))
        compare_value_0 <= wdata_i[COUNT_W-1:0];
      if (hit(addr_i, ADDR_COMPARE_1))
        compare_value_1 <= wdata_i[COUNT_W-1:0];
    end
  end

  // Mask register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      mask <= MASK_RST;
    else if (wr_i && hit(addr_i, ADDR_MASK))
      mask <= wdata_i[STATUS_W-1:0];
  end

  // Counter source select
  always_comb
  begin
    case (count_src)
      TMCCP_SRC_T1: count_tick = tick_t1;
      TMCCP_SRC_T4: count_tick = tick_t4;
      TMCCP_SRC_T16: count_tick = tick_t16;
      default: count_tick = 1'b0;
    endcase
  end

  assign next_up_counter = up_counter + 16'h0001;

  // Up-counter
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      up_counter <= '0;
    else if (prescaler_run && count_tick)
      up_counter <= next_up_counter;
  end

  // Events, taken on the tick that moves the counter onto the value
  always_comb
  begin
    event_set = '0;
    if (prescaler_run && count_tick)
    begin
      event_set[ST_MATCH0] = (next_up_counter == compare_value_0);
      event_set[ST_MATCH1] = (next_up_counter == compare_value_1);
      event_set[ST_OVERFLOW] = (up_counter == 16'hffff);
    end
  end

  assign w1c = (wr_i && hit(addr_i, ADDR_STATUS)) ? wdata_i[STATUS_W-1:0] : '0;

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      status <= '0;
    else
      status <= (status & ~w1c) | event_set;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(((status & ~w1c) | event_set) & mask);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      prescaler_run_o <= 1'b0;
    else
      prescaler_run_o <= prescaler_run;
  end

  // Read decode; upper bits and unmapped addresses read zero
  always_comb
  begin
    next_rdata = '0;
    case (addr_i)
      ADDR_RUN_CONTROL:
      begin
        next_rdata[RUN_BIT] = prescaler_run;
        next_rdata[SRC_MSB:SRC_LSB] = count_src;
      end
      ADDR_STATUS: next_rdata[STATUS_W-1:0] = status;
      ADDR_MASK: next_rdata[STATUS_W-1:0] = mask;
      ADDR_UP_COUNTER: next_rdata[COUNT_W-1:0] = up_counter;
      ADDR_COMPARE_0: next_rdata[COUNT_W-1:0] = compare_value_0;
      ADDR_COMPARE_1: next_rdata[COUNT_W-1:0] = compare_value_1;
      ADDR_CAPTURE_0: next_rdata[COUNT_W-1:0] = captured_value_0;
      ADDR_CAPTURE_1: next_rdata[COUNT_W-1:0] = captured_value_1;
      default: next_rdata = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= '0;
  end

endmodule : tmccp_timer

// ### bench/tmccp_timer_properties.sv
// Assertion checker on the timer channel ports
`timescale 1ns/1ps
module tmccp_timer_checker
  import tmccp_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [ADDR_W-1:0] addr_i, // Address
  input wire logic [DATA_W-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [DATA_W-1:0] rdata_o, // Read data
  input wire logic irq_o, // Interrupt
  input wire logic prescaler_run_o // Run state
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr(a);
    wr_i && addr_i == a;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  sequence s_ucnt_rd;
    s_rd(ADDR_UP_COUNTER) ##0 !prescaler_run_o && !$past(prescaler_run_o, 3);
  endsequence
  a_cmp_readback: assert property (
    s_wr(ADDR_COMPARE_0) ##2 s_rd(ADDR_COMPARE_0) |=> rdata_o == ($past(wdata_i, 3) & 32'h0000ffff))
    else $error("compare readback wrong");
  a_cmp_upper: assert property (s_rd(ADDR_COMPARE_1) |=> rdata_o[31:16] == 16'h0000)
    else $error("compare upper bits set");
  a_cap_upper: assert property (s_rd(ADDR_CAPTURE_0) or s_rd(ADDR_CAPTURE_1) |=> !(|rdata_o[31:16]))
    else $error("capture upper bits set");
  a_run_start: assert property (s_wr(ADDR_RUN_CONTROL) ##0 wdata_i[0] |-> ##[1:2] prescaler_run_o)
    else $error("run did not start");
  a_run_stop: assert property (s_wr(ADDR_RUN_CONTROL) ##0 !wdata_i[0] |-> ##[1:2] !prescaler_run_o)
    else $error("run did not stop");
  a_run_cause: assert property ($changed(prescaler_run_o) |->
    ($past(wr_i) && $past(addr_i) == ADDR_RUN_CONTROL) || ($past(wr_i, 2) && $past(addr_i, 2) == ADDR_RUN_CONTROL))
    else $error("run changed without a write");
  a_ucnt_hold: assert property (s_ucnt_rd ##2 s_ucnt_rd |=> rdata_o == $past(rdata_o, 2))
    else $error("stopped counter moved");
  a_irq_masked: assert property (s_wr(ADDR_MASK) ##0 wdata_i[2:0] == 3'h0 |-> ##2 !irq_o [*8])
    else $error("interrupt while fully masked");
endmodule : tmccp_timer_checker

bind tmccp_timer tmccp_timer_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .prescaler_run_o(prescaler_run_o));

// ### bench/tmccp_cg_model.sv
// Clock generator select fields and capture pin driver beside the timer channel
`timescale 1ns/1ps
module tmccp_cg_model
(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cfg_psel_i, // Wanted peripheral clock select
  input wire logic [2:0] cfg_gear_i, // Wanted gear code
  input wire logic [2:0] cfg_prck_i, // Wanted prescaler input code
  input wire logic fire0_i, // Capture 0 request
  input wire logic fire1_i, // Capture 1 request
  output logic periph_sel_o, // Peripheral clock select
  output logic [2:0] gear_sel_o, // Gear code
  output logic [2:0] prck_sel_o, // Prescaler input code
  output logic pin0_o, // Capture pin 0
  output logic pin1_o // Capture pin 1
);
  logic [5:0] sh0;
  logic [5:0] sh1;
  // Select fields change like a register write in the clock generator
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      periph_sel_o <= 1'b0;
      gear_sel_o <= 3'h0;
      prck_sel_o <= 3'h0;
    end
    else
    begin
      periph_sel_o <= cfg_psel_i;
      gear_sel_o <= cfg_gear_i;
      prck_sel_o <= cfg_prck_i;
    end
  end
  // Pulses last six cycles, well past the pin synchroniser; pins idle low from reset
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sh0 <= 6'h00;
      sh1 <= 6'h00;
    end
    else
    begin
      sh0 <= {sh0[4:0], fire0_i};
      sh1 <= {sh1[4:0], fire1_i};
    end
  end
  assign pin0_o = |sh0;
  assign pin1_o = |sh1;
endmodule : tmccp_cg_model

// ### bench/tmccp_timer_tb.sv
// Self-checking testbench for the timer channel
`timescale 1ns/1ps
module tmccp_timer_tb
  import tmccp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic c_psel = 1'b1;
  logic [2:0] c_gear = 3'h0;
  logic [2:0] c_prck = 3'h0;
  logic fire0 = 1'b0;
  logic fire1 = 1'b0;
  logic [31:0] rdata;
  logic psel, irq, run_o, pin0, pin1;
  logic [2:0] gear, prck;
  int bad_count = 0;
  int n_checks = 0;
  tmccp_cg_model cg (.clk_sys_i(clk), .rst_i(rst), .cfg_psel_i(c_psel), .cfg_gear_i(c_gear), .cfg_prck_i(c_prck),
    .fire0_i(fire0), .fire1_i(fire1), .periph_sel_o(psel), .gear_sel_o(gear), .prck_sel_o(prck), .pin0_o(pin0),
    .pin1_o(pin1));
  tmccp_timer dut (.clk_sys_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .periph_sel_i(psel), .gear_sel_i(gear), .prck_sel_i(prck), .capture0_pin_i(pin0),
    .capture1_pin_i(pin1), .irq_o(irq), .prescaler_run_o(run_o));
  initial
    forever #2.5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(what, exp, d);
  endtask : rd_chk
  task automatic run_ctl(input logic [1:0] s, input logic on);
    wr_reg(ADDR_RUN_CONTROL, {28'h0, s, 1'b0, on});
  endtask : run_ctl
  task automatic t_regs();
    rd_chk("compare0 reset", ADDR_COMPARE_0, 32'h0);
    rd_chk("compare1 reset", ADDR_COMPARE_1, 32'h0);
    wr_reg(ADDR_COMPARE_0, 32'hffffabcd);
    rd_chk("compare0", ADDR_COMPARE_0, 32'h0000abcd);
    wr_reg(ADDR_COMPARE_1, 32'h12345678);
    rd_chk("compare1", ADDR_COMPARE_1, 32'h00005678);
    wr_reg(8'h20, 32'h0000ffff);
    rd_chk("unmapped", 8'h20, 32'h0);
    rd_chk("compare0 kept", ADDR_COMPARE_0, 32'h0000abcd);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rate();
    logic [8:0] cfg [14] = '{9'h100, 9'h104, 9'h108, 9'h10c, 9'h110, 9'h114, 9'h101, 9'h102, 9'h080, 9'h0a4,
      9'h0c1, 9'h1c0, 9'h11c, 9'h020};
    int dv [14] = '{2, 4, 8, 16, 32, 64, 8, 16, 4, 16, 64, 2, 64, 2};
    logic [31:0] a, b;
    for (int i = 0; i < 14; i++)
    begin
      run_ctl(2'h0, 1'b0);
      {c_psel, c_gear, c_prck} <= cfg[i][8:2];
      run_ctl(cfg[i][1:0], 1'b1);
      repeat (2 * dv[i]) @(posedge clk);
      rd_reg(ADDR_UP_COUNTER, a);
      repeat (32 * dv[i] - 2) @(posedge clk);
      rd_reg(ADDR_UP_COUNTER, b);
      chk("steps per window", 32'd32, b - a);
    end
    $display("t_rate done");
  endtask : t_rate
  task automatic t_stop();
    logic [31:0] a;
    {c_psel, c_gear, c_prck} <= 7'h40;
    run_ctl(2'h2, 1'b1);
    repeat (23) @(posedge clk);
    run_ctl(2'h2, 1'b0);
    repeat (4) @(posedge clk);
    chk("run state off", 32'h0, {31'h0, run_o});
    rd_reg(ADDR_UP_COUNTER, a);
    rd_chk("held count", ADDR_UP_COUNTER, a);
    repeat (40) @(posedge clk);
    rd_chk("held count late", ADDR_UP_COUNTER, a);
    run_ctl(2'h3, 1'b1);
    repeat (40) @(posedge clk);
    rd_chk("no source selected", ADDR_UP_COUNTER, a);
    run_ctl(2'h2, 1'b0);
    run_ctl(2'h2, 1'b1);
    repeat (8) @(posedge clk);
    rd_chk("restart early", ADDR_UP_COUNTER, a);
    repeat (12) @(posedge clk);
    rd_chk("restart first step", ADDR_UP_COUNTER, a + 32'h1);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_match();
    logic [31:0] a;
    {c_psel, c_gear, c_prck} <= 7'h40;
    run_ctl(2'h0, 1'b0);
    rd_reg(ADDR_UP_COUNTER, a);
    wr_reg(ADDR_COMPARE_0, a + 32'h6);
    wr_reg(ADDR_COMPARE_1, a + 32'h9);
    wr_reg(ADDR_MASK, 32'h0);
    wr_reg(ADDR_STATUS, 32'h7);
    run_ctl(2'h0, 1'b1);
    repeat (40) @(posedge clk);
    run_ctl(2'h0, 1'b0);
    rd_chk("status masked", ADDR_STATUS, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr_reg(ADDR_MASK, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    wr_reg(ADDR_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("status one left", ADDR_STATUS, 32'h2);
    wr_reg(ADDR_MASK, 32'h2);
    repeat (3) @(posedge clk);
    #1 chk("irq match1", 32'h1, {31'h0, irq});
    wr_reg(ADDR_STATUS, 32'h2);
    rd_chk("status clear", ADDR_STATUS, 32'h0);
    $display("t_match done");
  endtask : t_match
  task automatic t_capture();
    logic [31:0] v;
    rd_reg(ADDR_UP_COUNTER, v);
    @(posedge clk);
    fire0 <= 1'b1;
    @(posedge clk);
    fire0 <= 1'b0;
    repeat (12) @(posedge clk);
    rd_chk("capture0", ADDR_CAPTURE_0, v);
    wr_reg(ADDR_CAPTURE_0, 32'h1234);
    rd_chk("capture0 read only", ADDR_CAPTURE_0, v);
    @(posedge clk);
    fire1 <= 1'b1;
    @(posedge clk);
    fire1 <= 1'b0;
    repeat (12) @(posedge clk);
    rd_chk("capture1", ADDR_CAPTURE_1, v);
    $display("t_capture done");
  endtask : t_capture
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rate();
    t_stop();
    t_match();
    t_capture();
    tally_and_finish();
  end
endmodule : tmccp_timer_tb
